//--- src/pci_cmd_status_cfg.svh
// Purpose: Offsets, field positions and reset values of the command and status registers.
// Assumes: Included by bare name from the package and the register bank module.
// Notes:   Definitions only.
`ifndef PCI_CMD_STATUS_CFG_SVH
`define PCI_CMD_STATUS_CFG_SVH

// Configuration dword index holding command (low half) and status (high half).
`define CFG_CMD_DWORD_INDEX    6'h01
`define CFG_CMD_BYTE_OFFSET    8'h04
`define CFG_STATUS_BYTE_OFFSET 8'h06

// Command register fields.
`define CMD_IO_EN_BIT          0
`define CMD_MEM_EN_BIT         1
`define CMD_MASTER_EN_BIT      2
`define CMD_PALETTE_EN_BIT     5
`define CMD_PARITY_EN_BIT      6
`define CMD_SYSTEM_ERROR_ENABLE_BIT        8
`define CMD_WRITABLE_MASK      16'h0167
`define CMD_RESET_VALUE        16'h0000

// Status register fields.
`define STS_DATA_PARITY_BIT    8
`define STS_TARGET_ABORT_SIGNALLED_BIT       11
`define STS_TARGET_ABORT_RECEIVED_BIT       12
`define STS_MASTER_ABORT_RECEIVED_BIT         13
`define STS_SYS_ERR_BIT        14
`define STS_PARITY_SEEN_BIT    15
`define STS_HARDWIRED          16'h0210
`define STS_RESET_VALUE        16'h0210

// Width of the configuration data path and byte enables.
`define CFG_DATA_WIDTH         32
`define CFG_BE_WIDTH           4
`define CFG_INDEX_WIDTH        6
`define STS_FLAG_COUNT         6

`endif

//--- src/pci_cmd_status_pkg.sv
// Purpose: Types shared by the command and status register bank.
// Assumes: The cfg header supplies widths.
// Notes:   Holds types only.
`include "pci_cmd_status_cfg.svh"

package pci_cmd_status_pkg;

  // One configuration access from the bus target, same clock.
  typedef struct packed {
    logic                              read;
    logic                              write;
    logic [`CFG_INDEX_WIDTH-1:0]       index;
    logic [`CFG_BE_WIDTH-1:0]          byte_en;
    logic [`CFG_DATA_WIDTH-1:0]        wdata;
  } cfg_req_t;

  // Bus events seen by the surrounding bus logic, one-cycle pulses.
  typedef struct packed {
    logic addr_parity_err;
    logic data_parity_err;
    logic perr_while_master;
    logic master_abort;
    logic target_abort_rx;
    logic target_abort_tx;
  } bus_event_t;

  // Cycle decode hits offered for claiming.
  typedef struct packed {
    logic mem_hit;
    logic io_hit;
    logic palette_write;
    logic special_cycle;
    logic master_request;
  } decode_t;

  // Permissions and claims returned to the bus logic.
  typedef struct packed {
    logic claim_mem;
    logic claim_io;
    logic palette_capture;
    logic master_allowed;
    logic plain_write_only;
  } claim_t;

endpackage

//--- src/w1c_flag.sv
// Purpose: One sticky status flag, set by hardware, cleared by writing one.
// Assumes: Set and clear are same-clock pulses; reset already synchronised.
// Notes:   A set in the clear cycle wins so no event is lost.
`timescale 1ns/1ns

module w1c_flag
(
  // Clock and reset.
  input  wire logic i_clock,
  input  wire logic i_reset_n,
  input  wire logic i_clock_en,
  // Set and clear requests.
  input  wire logic i_set,
  input  wire logic i_clear,
  // Flag value.
  output logic      o_flag
);

  logic next_flag;

  // Set has priority over a write-one clear in the same cycle.
  always_comb
  begin
    next_flag = o_flag;
    if (i_set)
    begin
      next_flag = 1'b1;
    end
    else if (i_clear)
    begin
      next_flag = 1'b0; // see [RULE13]
    end
  end

  // Register the flag; frozen while the clock enable is low.
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_flag <= 1'b0;
    end
    else if (i_clock_en)
    begin
      o_flag <= next_flag;
    end
  end

endmodule

//--- src/pci_command_status_regs.sv
// Purpose: Command and status configuration registers of a bus bridge target.
// Assumes: Requests, events and decode hits come from bus logic on i_clock.
// Notes:   Command in low half, status in high half of configuration dword 04h.
//
// What this block does
// [RULE1] Command bits 15 to 10 read zero; writes there do nothing.
// [RULE2] Back-to-back enable bit 9 reads zero; no fast back-to-back issue.
// [RULE3] Bit 8 system_error_enable gates the SERR driver; reset value zero.
// [RULE4] Address parity error reaches SERR only with bits 8 and 6 set.
// [RULE5] Stepping control bit 7 is hardwired zero.
// [RULE6] Bit 6 parity_response_enable: data errors on PERR, address errors on SERR.
// [RULE7] Palette snoop bit 5 set: do not claim palette writes, capture data.
// [RULE8] Write-invalidate bit 4 is zero; plain memory writes are used instead.
// [RULE9] Special cycle bit 3 is zero; special cycles are never answered.
// [RULE10] Master activity only while initiator_enable bit 2 is one.
// [RULE11] Memory cycles are claimed only while bit 1 is one.
// [RULE12] I/O cycles are claimed only while bit 0 is one.
// [RULE13] Writing one clears a status flag; writing zero leaves it.
// [RULE14] Status bit 15 sets on any parity error regardless of enables.
// [RULE15] Status bits 10 to 9 read binary 01, medium select timing.
// [RULE16] Status bit 8 sets on PERR while mastering with parity response enabled.
// [RULE17] Bits 13 and 12 record received aborts; bit 11 a signalled target abort.
// [RULE18] Host reaches command at 04h and status at 06h via configuration cycles.
`timescale 1ns/1ns
`include "pci_cmd_status_cfg.svh"

module pci_command_status_regs
#(
  parameter int CFG_INDEX_WIDTH = `CFG_INDEX_WIDTH
)
(
  // Clock, reset and clock enable.
  input  wire logic                              i_clock,
  input  wire logic                              i_reset_n,
  input  wire logic                              i_clock_en,
  // Configuration access port.
  input  wire pci_cmd_status_pkg::cfg_req_t      i_cfg_req,
  output logic                                   o_cfg_ack,
  output logic [`CFG_DATA_WIDTH-1:0]             o_cfg_rdata,
  // Bus events and decode hits.
  input  wire pci_cmd_status_pkg::bus_event_t    i_bus_event,
  input  wire pci_cmd_status_pkg::decode_t       i_decode,
  // Claims and permissions.
  output pci_cmd_status_pkg::claim_t             o_claim,
  // Error pin drivers, open drain: high enables the low drive.
  output logic                                   o_serr_oe,
  output logic                                   o_perr_oe,
  // Register views.
  output logic [15:0]                            o_command,
  output logic [15:0]                            o_status
);

  // Refuse any index width other than the configuration dword index width.
  initial
  begin
    if (CFG_INDEX_WIDTH != `CFG_INDEX_WIDTH)
    begin
      $error("CFG_INDEX_WIDTH must match the configuration dword index width");
    end
  end

  // Reset release through two flops; asynchronous assertion.
  logic reset_meta_n;
  logic reset_sync_n;

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      reset_meta_n <= 1'b0;
      reset_sync_n <= 1'b0;
    end
    else
    begin
      reset_meta_n <= 1'b1;
      reset_sync_n <= reset_meta_n;
    end
  end

  // True when an access addresses the command and status dword.
  function automatic logic hits_cmd_dword(input logic [`CFG_INDEX_WIDTH-1:0] index);
    hits_cmd_dword = (index == `CFG_CMD_DWORD_INDEX);
  endfunction

  logic [15:0] command_q;
  logic [15:0] next_command;
  logic        cmd_write;
  logic        sts_write;
  logic [15:0] write_mask;
  logic [15:0] clear_bits;

  // Decode write and build the per-byte mask for each half.
  always_comb
  begin
    cmd_write  = 1'b0;
    sts_write  = 1'b0;
    write_mask = 16'h0000;
    clear_bits = 16'h0000;
    if (i_cfg_req.write && hits_cmd_dword(i_cfg_req.index)) // see [RULE18]
    begin
      cmd_write  = 1'b1;
      sts_write  = 1'b1;
      write_mask = {{8{i_cfg_req.byte_en[1]}}, {8{i_cfg_req.byte_en[0]}}};
      clear_bits = i_cfg_req.wdata[31:16] &
                   {{8{i_cfg_req.byte_en[3]}}, {8{i_cfg_req.byte_en[2]}}};
    end
  end

  // Only writable command bits take new values; hardwired ones stay zero.
  always_comb
  begin
    next_command = command_q;
    if (cmd_write)
    begin
      next_command = (command_q & ~(write_mask & `CMD_WRITABLE_MASK)) |
                     (i_cfg_req.wdata[15:0] & write_mask & `CMD_WRITABLE_MASK); // see [RULE1]
    end
    next_command = next_command & `CMD_WRITABLE_MASK; // see [RULE2] see [RULE5] see [RULE8]
  end

  always_ff @(posedge i_clock or negedge reset_sync_n)
  begin
    if (!reset_sync_n)
    begin
      command_q <= `CMD_RESET_VALUE;
    end
    else if (i_clock_en)
    begin
      command_q <= next_command;
    end
  end

  // Named views of the writable command bits.
  logic system_error_enable;
  logic parity_en;
  logic palette_en;
  logic master_en;
  logic mem_en;
  logic io_en;

  assign system_error_enable    = command_q[`CMD_SYSTEM_ERROR_ENABLE_BIT];
  assign parity_en  = command_q[`CMD_PARITY_EN_BIT];
  assign palette_en = command_q[`CMD_PALETTE_EN_BIT];
  assign master_en  = command_q[`CMD_MASTER_EN_BIT];
  assign mem_en     = command_q[`CMD_MEM_EN_BIT];
  assign io_en      = command_q[`CMD_IO_EN_BIT];

  // Error pin decisions, taken in the event cycle and registered out.
  logic next_serr_oe;
  logic next_perr_oe;

  always_comb
  begin
    next_serr_oe = i_bus_event.addr_parity_err & system_error_enable & parity_en; // see [RULE3] see [RULE4]
    next_perr_oe = i_bus_event.data_parity_err & parity_en;           // see [RULE6]
  end

  // Status flag set conditions in bit order of the sticky flags.
  logic [`STS_FLAG_COUNT-1:0] flag_set;
  logic [`STS_FLAG_COUNT-1:0] flag_clear;
  logic [`STS_FLAG_COUNT-1:0] flag_q;
  localparam int FLAG_POS [`STS_FLAG_COUNT] = '{`STS_DATA_PARITY_BIT, `STS_TARGET_ABORT_SIGNALLED_BIT,
                                                `STS_TARGET_ABORT_RECEIVED_BIT, `STS_MASTER_ABORT_RECEIVED_BIT,
                                                `STS_SYS_ERR_BIT, `STS_PARITY_SEEN_BIT};

  always_comb
  begin
    flag_set[0] = i_bus_event.perr_while_master & parity_en;      // see [RULE16]
    flag_set[1] = i_bus_event.target_abort_tx;                    // see [RULE17]
    flag_set[2] = i_bus_event.target_abort_rx;                    // see [RULE17]
    flag_set[3] = i_bus_event.master_abort;                       // see [RULE17]
    flag_set[4] = next_serr_oe;
    flag_set[5] = i_bus_event.addr_parity_err |
                  i_bus_event.data_parity_err;                    // see [RULE14]
  end

  // One sticky flag per status bit; clear taken from the written ones.
  genvar g;
  generate
    for (g = 0; g < `STS_FLAG_COUNT; g++)
    begin : gen_flag
      assign flag_clear[g] = sts_write & clear_bits[FLAG_POS[g]]; // see [RULE13]
      w1c_flag u_flag
      (
        .i_clock    (i_clock),
        .i_reset_n  (reset_sync_n),
        .i_clock_en (i_clock_en),
        .i_set      (flag_set[g]),
        .i_clear    (flag_clear[g]),
        .o_flag     (flag_q[g])
      );
    end
  endgenerate

  // Status word: hardwired capability bits plus sticky flags.
  logic [15:0] status_word;

  always_comb
  begin
    status_word = `STS_HARDWIRED; // see [RULE15]
    for (int i = 0; i < `STS_FLAG_COUNT; i++)
    begin
      status_word[FLAG_POS[i]] = flag_q[i];
    end
  end

  // Claim decisions; special cycles and write-invalidate are never offered.
  pci_cmd_status_pkg::claim_t next_claim;

  always_comb
  begin
    next_claim.claim_mem        = i_decode.mem_hit & mem_en &
                                  ~(i_decode.palette_write & palette_en); // see [RULE11] see [RULE7]
    next_claim.claim_io         = i_decode.io_hit & io_en &
                                  ~(i_decode.palette_write & palette_en); // see [RULE12] see [RULE7]
    next_claim.palette_capture  = i_decode.palette_write & palette_en;    // see [RULE7]
    next_claim.master_allowed   = i_decode.master_request & master_en &
                                  ~i_decode.special_cycle;                // see [RULE10] see [RULE9]
    next_claim.plain_write_only = 1'b1;                                   // see [RULE8]
  end

  // Read data and acknowledge; other dwords acknowledge with zero data.
  logic                       next_ack;
  logic [`CFG_DATA_WIDTH-1:0] next_rdata;

  always_comb
  begin
    next_ack   = i_cfg_req.read | i_cfg_req.write;
    next_rdata = '0;
    if (i_cfg_req.read && hits_cmd_dword(i_cfg_req.index))
    begin
      next_rdata = {status_word, command_q};
    end
  end

  // All outputs come straight from flops.
  always_ff @(posedge i_clock or negedge reset_sync_n)
  begin
    if (!reset_sync_n)
    begin
      o_cfg_ack   <= 1'b0;
      o_cfg_rdata <= '0;
      o_claim     <= '0;
      o_serr_oe   <= 1'b0;
      o_perr_oe   <= 1'b0;
      o_command   <= `CMD_RESET_VALUE;
      o_status    <= `STS_RESET_VALUE;
    end
    else if (i_clock_en)
    begin
      o_cfg_ack   <= next_ack;
      o_cfg_rdata <= next_rdata;
      o_claim     <= next_claim;
      o_serr_oe   <= next_serr_oe;
      o_perr_oe   <= next_perr_oe;
      o_command   <= next_command;
      o_status    <= status_word;
    end
  end

endmodule

//--- verif/pci_cmd_status_chk.sv
// Purpose: Bound checker for the command and status register bank.
// Assumes: Outputs follow their cause by one cycle, status by two.
// Notes:   Bound to the bank at the foot of this file.
`timescale 1ns/1ns

module pci_cmd_status_chk
(
  // Clock, reset and requests.
  input wire logic                           i_clock,
  input wire logic                           i_reset_n,
  input wire pci_cmd_status_pkg::cfg_req_t   i_cfg_req,
  input wire pci_cmd_status_pkg::bus_event_t i_bus_event,
  input wire pci_cmd_status_pkg::decode_t    i_decode,
  // Outputs of the bank.
  input wire logic                           o_cfg_ack,
  input wire pci_cmd_status_pkg::claim_t     o_claim,
  input wire logic                           o_serr_oe,
  input wire logic                           o_perr_oe,
  input wire logic [15:0]                    o_command,
  input wire logic [15:0]                    o_status
);
  // One clock domain, so reset masks every check at once.
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  a_rsvd_zero:
    assert property (o_command[15:10] == 6'h00) else $error("reserved command bits set");
  a_fixed_zero:
    assert property (!o_command[9] && !o_command[7] && o_command[4:3] == 2'h0)
      else $error("hardwired command bit set");
  a_serr_gate:
    assert property (o_serr_oe |-> $past(i_bus_event.addr_parity_err && o_command[8]
      && o_command[6])) else $error("system error drive without cause");
  a_perr_gate:
    assert property (o_perr_oe |-> $past(i_bus_event.data_parity_err && o_command[6]))
      else $error("parity drive without cause");
  a_mem_claim:
    assert property (o_claim.claim_mem |-> $past(i_decode.mem_hit && o_command[1]))
      else $error("memory claim while disabled");
  a_io_claim:
    assert property (o_claim.claim_io |-> $past(i_decode.io_hit && o_command[0]))
      else $error("io claim while disabled");
  a_master_gate:
    assert property (o_claim.master_allowed |-> $past(o_command[2] && !i_decode.special_cycle))
      else $error("master activity while disabled");
  a_snoop_hold:
    assert property (i_decode.palette_write && o_command[5] |=> !o_claim.claim_mem
      && !o_claim.claim_io && o_claim.palette_capture) else $error("palette write claimed");
  a_parity_seen:
    assert property (i_bus_event.addr_parity_err || i_bus_event.data_parity_err
      |-> ##2 o_status[15]) else $error("parity error not recorded");
  a_speed_bits:
    assert property (o_status[10:9] == 2'h1) else $error("select timing bits wrong");
  a_ack_after:
    assert property (i_cfg_req.read || i_cfg_req.write |=> o_cfg_ack)
      else $error("configuration access not acknowledged");
endmodule

bind pci_command_status_regs pci_cmd_status_chk pci_cmd_status_chk_i
(
  .i_clock, .i_reset_n, .i_cfg_req, .i_bus_event, .i_decode, .o_cfg_ack,
  .o_claim, .o_serr_oe, .o_perr_oe, .o_command, .o_status
);

//--- verif/bus_agent_model.sv
// Purpose: Far-side bus logic offering events and decode hits.
// Assumes: Driven from the bench at falling edges.
// Notes:   Events are single-cycle pulses, as the bus produces them.
`timescale 1ns/1ns

module bus_agent_model
(
  // Clock.
  input  wire logic                      i_clock,
  // Events and decode levels toward the bank.
  output pci_cmd_status_pkg::bus_event_t o_event,
  output pci_cmd_status_pkg::decode_t    o_decode
);
  // Idle bus carries no events and no hits.
  initial
  begin
    o_event = '0;
    o_decode = '0;
  end

  // One bus cycle; values drop after one clock so no event is seen twice.
  task automatic cycle(input pci_cmd_status_pkg::bus_event_t e,
                       input pci_cmd_status_pkg::decode_t d);
    @(negedge i_clock);
    o_event = e;
    o_decode = d;
    @(negedge i_clock);
    o_event = '0;
    o_decode = '0;
  endtask
endmodule

//--- verif/tb_top.sv
// Purpose: Self-checking bench for the command and status registers.
// Assumes: Views are sampled at the falling edge after their update.
// Notes:   Clock enable is held high throughout.
`timescale 1ns/1ns

module tb_top;
  logic                           i_clock;
  logic                           i_reset_n;
  pci_cmd_status_pkg::cfg_req_t   req;
  pci_cmd_status_pkg::bus_event_t ev;
  pci_cmd_status_pkg::decode_t    dec;
  pci_cmd_status_pkg::claim_t     claim;
  logic                           ack;
  logic                           serr_oe;
  logic                           perr_oe;
  logic [31:0]                    rdata;
  logic [15:0]                    cmd;
  logic [15:0]                    sts;
  logic [15:0]                    exp_sts;
  logic [5:0]                     e;
  int                             failures;
  int                             tests_run;
  logic [15:0]                    cmds [2] = '{16'h0000, 16'h0167};
  logic [15:0]                    ecmd [2] = '{16'h0000, 16'h0140};
  logic [4:0]                     decs [5] = '{5'h10, 5'h08, 5'h04, 5'h03, 5'h01};

  // Free-running clock, 20 ns period.
  initial
  begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  pci_command_status_regs pci_command_status_regs_i
  (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_clock_en(1'b1), .i_cfg_req(req),
    .o_cfg_ack(ack), .o_cfg_rdata(rdata), .i_bus_event(ev), .i_decode(dec),
    .o_claim(claim), .o_serr_oe(serr_oe), .o_perr_oe(perr_oe),
    .o_command(cmd), .o_status(sts)
  );

  bus_agent_model bus_agent_model_i
  (
    .i_clock(i_clock), .o_event(ev), .o_decode(dec)
  );

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One access to dword 04h; ack and read data are checked in their one cycle.
  task automatic cfg(input logic rd, input logic [3:0] be, input logic [31:0] wd,
                     input logic [31:0] exp);
    @(negedge i_clock);
    req = '{read: rd, write: !rd, index: 6'h01, byte_en: be, wdata: wd};
    @(negedge i_clock);
    req = '0;
    chk("ack", 32'h0000_0001, {31'h0000_0000, ack});
    if (rd)
      chk("rdata", exp, rdata);
  endtask

  function automatic pci_cmd_status_pkg::claim_t exp_claim(input logic [4:0] d,
                                                           input logic [15:0] c);
    exp_claim = {d[4] & c[1], d[3] & c[0], d[2] & c[5], d[0] & c[2] & !d[1], 1'b1};
  endfunction

  task automatic wrap_up();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog; the whole sequence needs well under a thousand cycles.
  initial
  begin
    #100000;
    failures++;
    wrap_up();
  end

  // Main sequence.
  initial
  begin
    i_reset_n = 1'b0;
    req = '0;
    failures = 0;
    tests_run = 0;
    repeat (8) @(negedge i_clock);
    i_reset_n = 1'b1;
    repeat (3) @(negedge i_clock);
    chk("status", 32'h0000_0210, {16'h0000, sts});
    cfg(1'b1, 4'hf, 32'h0000_0000, 32'h0210_0000);
    cfg(1'b0, 4'hf, 32'h0000_ffff, 32'h0000_0000);
    cfg(1'b1, 4'hf, 32'h0000_0000, 32'h0210_0167);
    cfg(1'b0, 4'h1, 32'h0000_0000, 32'h0000_0000);
    cfg(1'b1, 4'hf, 32'h0000_0000, 32'h0210_0100);
    foreach (cmds[k])
    begin
      cfg(1'b0, 4'h3, {16'h0000, cmds[k]}, 32'h0000_0000);
      foreach (decs[j])
      begin
        bus_agent_model_i.cycle('0, decs[j]);
        chk("claim", 32'(exp_claim(decs[j], cmds[k])), 32'(claim));
      end
    end
    foreach (ecmd[k])
    begin
      cfg(1'b0, 4'h3, {16'h0000, ecmd[k]}, 32'h0000_0000);
      exp_sts = 16'h0210;
      for (int i = 0; i < 6; i++)
      begin
        e = 6'h20 >> i;
        bus_agent_model_i.cycle(e, '0);
        chk("serr", {31'h0000_0000, e[5] & ecmd[k][8]}, {31'h0000_0000, serr_oe});
        chk("perr", {31'h0000_0000, e[4] & ecmd[k][6]}, {31'h0000_0000, perr_oe});
        @(negedge i_clock);
        if (i < 2)
          exp_sts[15] = 1'b1;
        if (i == 0)
          exp_sts[14] = ecmd[k][8];
        if (i == 2)
          exp_sts[8] = ecmd[k][6];
        if (i > 2)
          exp_sts[16 - i] = 1'b1;
        chk("status", {16'h0000, exp_sts}, {16'h0000, sts});
      end
      cfg(1'b0, 4'hc, 32'h0000_0000, 32'h0000_0000);
      cfg(1'b1, 4'hf, 32'h0000_0000, {exp_sts, ecmd[k]});
      cfg(1'b0, 4'hc, 32'hffff_0000, 32'h0000_0000);
      cfg(1'b1, 4'hf, 32'h0000_0000, {16'h0210, ecmd[k]});
    end
    wrap_up();
  end
endmodule
